// ===== verilog/core_regs_pkg.sv
// shared constants for the core register set
package core_regs_pkg;

	// ========================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_PC    = 12'h000;
	localparam logic [11:0] OFS_ACC   = 12'h004;
	localparam logic [11:0] OFS_TMP   = 12'h008;
	localparam logic [11:0] OFS_IDX   = 12'h00c;
	localparam logic [11:0] OFS_EXT   = 12'h010;
	localparam logic [11:0] OFS_STK   = 12'h014;
	localparam logic [11:0] OFS_PS    = 12'h018;
	localparam logic [11:0] OFS_OP    = 12'h01c;
	localparam logic [11:0] OFS_GPR   = 12'h020;
	localparam logic [11:0] OFS_PROBE = 12'h024;

	// ========================================
	// condition code byte field positions
	localparam int CC_H    = 7;
	localparam int CC_I    = 6;
	localparam int CC_IL_H = 5;
	localparam int CC_IL_L = 4;
	localparam int CC_N    = 3;
	localparam int CC_Z    = 2;
	localparam int CC_V    = 1;
	localparam int CC_C    = 0;

	// operation register fields
	localparam int OPF_WIDE  = 3;
	localparam int OPF_OP_H  = 2;

	// ========================================
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0]  RST_BANK = 8'h00;
	localparam logic [7:0]  RST_CCR  = 8'h30;

	// ========================================
	// memory map
	localparam logic [15:0] IO_END      = 16'h0080;
	localparam logic [15:0] GPR_BASE    = 16'h0100;
	localparam logic [15:0] PROG_BASE   = 16'h8000;
	localparam logic [15:0] VECTOR_BASE = 16'hffc0;

	typedef enum logic [1:0] {
		RGN_IO     = 2'b00,
		RGN_DATA   = 2'b01,
		RGN_PROG   = 2'b10,
		RGN_VECTOR = 2'b11
	} region_e;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ADD  = 3'b001,
		OP_SUB  = 3'b010,
		OP_SHL  = 3'b011,
		OP_SHR  = 3'b100,
		OP_STEP = 3'b101
	} alu_op_e;

endpackage

// ===== verilog/flag_calc.sv
// result and condition flags for one accumulator operation
`timescale 1ns/1ps
module flag_calc
	import core_regs_pkg::*;
(
	input  wire logic [15:0] acc_i,    // accumulator
	input  wire logic [15:0] tmp_i,    // temporary accumulator
	input  wire logic [2:0]  op_i,     // operation code
	input  wire logic        wide_i,   // 16-bit operation
	output logic      [15:0] res_o,    // new accumulator value
	output logic             h_o,      // half carry
	output logic             n_o,      // negative
	output logic             z_o,      // zero
	output logic             v_o,      // overflow
	output logic             c_o       // carry / shift-out
);

	// ========================================
	// operands
	wire logic [15:0] opa  = wide_i ? acc_i : {8'h00, acc_i[7:0]};
	wire logic [15:0] opb  = wide_i ? tmp_i : {8'h00, tmp_i[7:0]};
	wire logic        is_sub = (op_i == OP_SUB);
	wire logic [16:0] sum  = is_sub ? ({1'b0, opa} - {1'b0, opb})
	                                : ({1'b0, opa} + {1'b0, opb});
	wire logic [15:0] shl  = {opa[14:0], 1'b0};
	wire logic [15:0] shr  = {1'b0, opa[15:1]};
	wire logic        sa   = wide_i ? opa[15] : opa[7];
	wire logic        sb   = wide_i ? opb[15] : opb[7];

	wire logic [15:0] raw  = (op_i == OP_SHL) ? shl :
	                         (op_i == OP_SHR) ? shr : sum[15:0];
	wire logic        sr   = wide_i ? raw[15] : raw[7];

	// upper byte of the accumulator survives byte operations
	assign res_o = wide_i ? raw : {acc_i[15:8], raw[7:0]};
	assign h_o   = opa[4] ^ opb[4] ^ sum[4];
	assign n_o   = sr;
	assign z_o   = wide_i ? (raw == 16'h0000) : (raw[7:0] == 8'h00);
	assign v_o   = is_sub ? ((sa != sb) && (sr != sa))
	                      : ((sa == sb) && (sr != sa));
	assign c_o   = (op_i == OP_SHL) ? sa :
	               (op_i == OP_SHR) ? opa[0] :
	               (wide_i ? sum[16] : sum[8]);

endmodule // flag_calc

// ===== verilog/addr_map.sv
// register bank address forming and memory region decode
`timescale 1ns/1ps
module addr_map
	import core_regs_pkg::*;
#(
	parameter int NUM_BANKS = 32
)(
	input  wire logic [7:0]  bank_pointer_i,  // bank pointer
	input  wire logic [2:0]  gpr_num_i,       // register number
	input  wire logic [15:0] probe_i,         // address to classify
	output logic      [15:0] gpr_addr_o,      // physical register address
	output logic      [1:0]  region_o         // region code
);

	localparam int BW = $clog2(NUM_BANKS);
	// bank bits beyond the fitted memory are ignored, so a stray pointer wraps
	wire logic [4:0]  bank = 5'(bank_pointer_i[BW-1:0]);

	assign gpr_addr_o = GPR_BASE + {8'h00, bank, gpr_num_i};

	// one flat 64K space: io at the bottom, program with vectors on top
	assign region_o = (probe_i < IO_END)       ? RGN_IO :
	                  (probe_i < PROG_BASE)    ? RGN_DATA :
	                  (probe_i >= VECTOR_BASE) ? RGN_VECTOR : RGN_PROG;

endmodule // addr_map

// ===== verilog/cpu_register_set_and_flags.sv
// dedicated core register set with condition flags, behind an apb slave
`timescale 1ns/1ps
module cpu_register_set_and_flags
	import core_regs_pkg::*;
#(
	parameter int NUM_BANKS = 32,
	parameter int ADDR_W    = 12
)(
	input  wire logic              mclk_i,         // core clock
	input  wire logic              rst_i,          // synchronous reset, high
	input  wire logic              psel_i,         // apb select
	input  wire logic              penable_i,      // apb enable
	input  wire logic              pwrite_i,       // apb write
	input  wire logic [ADDR_W-1:0] paddr_i,        // apb byte address
	input  wire logic [31:0]       pwdata_i,       // apb write data
	output logic      [31:0]       prdata_o,       // apb read data
	output logic                   pready_o,       // apb ready
	output logic                   pslverr_o,      // apb error
	input  wire logic              irq_req_i,      // interrupt request
	input  wire logic [1:0]        irq_level_i,    // request level
	output logic                   irq_take_o,     // request accepted
	output logic      [15:0]       program_counter_o, // next fetch address
	output logic      [15:0]       program_status_o,  // status word
	output logic      [15:0]       gpr_addr_o      // active register address
);

	// ========================================
	// bus decode
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;

	wire logic [11:0] a12 = 12'(paddr_i);
	wire logic sel_pc    = (a12 == OFS_PC);
	wire logic sel_acc   = (a12 == OFS_ACC);
	wire logic sel_tmp   = (a12 == OFS_TMP);
	wire logic sel_idx   = (a12 == OFS_IDX);
	wire logic sel_ext   = (a12 == OFS_EXT);
	wire logic sel_stk   = (a12 == OFS_STK);
	wire logic sel_ps    = (a12 == OFS_PS);
	wire logic sel_op    = (a12 == OFS_OP);
	wire logic sel_gpr   = (a12 == OFS_GPR);
	wire logic sel_probe = (a12 == OFS_PROBE);
	wire logic hit = sel_pc | sel_acc | sel_tmp | sel_idx | sel_ext | sel_stk
	               | sel_ps | sel_op | sel_gpr | sel_probe;

	// ready comes one cycle into the access phase; a write commits only there
	wire logic in_access = psel_i & penable_i;
	wire logic commit    = in_access & pready_q;
	wire logic wr        = commit & pwrite_i & hit;

	// ========================================
	// register storage
	logic [15:0] pc_q;
	logic [15:0] acc_q;
	logic [15:0] tmp_q;
	logic [15:0] idx_q;
	logic [15:0] ext_q;
	logic [15:0] stk_q;
	logic [7:0]  bank_q;
	logic [7:0]  ccr_q;
	logic [3:0]  lastop_q;
	logic [2:0]  gpr_num_q;
	logic [15:0] probe_q;
	logic        irq_take_q;
	logic [15:0] gpr_addr_q;

	// ========================================
	// operation launch
	wire logic [2:0]  op_code = pwdata_i[OPF_OP_H:0];
	wire logic        op_wide = pwdata_i[OPF_WIDE];
	wire logic        op_go   = wr & sel_op;
	wire logic        is_arith = (op_code == OP_ADD) | (op_code == OP_SUB);
	wire logic        is_shift = (op_code == OP_SHL) | (op_code == OP_SHR);
	wire logic        do_alu   = op_go & (is_arith | is_shift);
	wire logic        do_step  = op_go & (op_code == OP_STEP);

	logic [15:0] alu_res;
	logic        f_h;
	logic        f_n;
	logic        f_z;
	logic        f_v;
	logic        f_c;

	flag_calc u_flags (
		.acc_i  (acc_q),
		.tmp_i  (tmp_q),
		.op_i   (op_code),
		.wide_i (op_wide),
		.res_o  (alu_res),
		.h_o    (f_h),
		.n_o    (f_n),
		.z_o    (f_z),
		.v_o    (f_v),
		.c_o    (f_c)
	);

	logic [15:0] gpr_addr;
	logic [1:0]  region;

	addr_map #(
		.NUM_BANKS (NUM_BANKS)
	) u_map (
		.bank_pointer_i (bank_q),
		.gpr_num_i      (gpr_num_q),
		.probe_i        (probe_q),
		.gpr_addr_o     (gpr_addr),
		.region_o       (region)
	);

	// ========================================
	// next-state selection
	// shifts keep overflow and half carry; only add and subtract touch them
	wire logic [7:0] ccr_alu = {is_arith ? f_h : ccr_q[CC_H],
	                            ccr_q[CC_I], ccr_q[CC_IL_H:CC_IL_L],
	                            f_n, f_z,
	                            is_arith ? f_v : ccr_q[CC_V],
	                            f_c};
	wire logic [7:0]  ccr_d  = (wr & sel_ps) ? pwdata_i[7:0] :
	                           do_alu ? ccr_alu : ccr_q;
	wire logic [7:0]  bank_d = (wr & sel_ps) ? pwdata_i[15:8] : bank_q;
	wire logic [15:0] acc_d  = (wr & sel_acc) ? pwdata_i[15:0] :
	                           do_alu ? alu_res : acc_q;
	wire logic [15:0] pc_d   = (wr & sel_pc) ? pwdata_i[15:0] :
	                           do_step ? pc_q + 16'h0001 : pc_q;

	wire logic [31:0] rd_mux =
		sel_pc    ? {16'h0000, pc_q} :
		sel_acc   ? {16'h0000, acc_q} :
		sel_tmp   ? {16'h0000, tmp_q} :
		sel_idx   ? {16'h0000, idx_q} :
		sel_ext   ? {16'h0000, ext_q} :
		sel_stk   ? {16'h0000, stk_q} :
		sel_ps    ? {16'h0000, bank_q, ccr_q} :
		sel_op    ? {28'h0000000, lastop_q} :
		sel_gpr   ? {gpr_addr, 13'h0000, gpr_num_q} :
		sel_probe ? {14'h0000, region, probe_q} : 32'h00000000;

	// request level 00 is highest priority, so smaller wins
	// codes 00 and 01 share the top level, so 01 folds onto 00 before comparing
	wire logic [1:0] req_rank   = (irq_level_i == 2'h1) ? 2'h0 : irq_level_i;
	wire logic [1:0] allow_rank = (ccr_q[CC_IL_H:CC_IL_L] == 2'h1) ? 2'h0
	                            : ccr_q[CC_IL_H:CC_IL_L];
	wire logic take_d = irq_req_i & ccr_q[CC_I]
	                  & (req_rank < allow_rank);

	// ========================================
	// bus answer
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= in_access & ~pready_q;
			prdata_q  <= (in_access & ~pready_q & ~pwrite_i) ? rd_mux : prdata_q;
			pslverr_q <= in_access & ~pready_q & ~hit;
		end
	end

	// ========================================
	// register updates
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pc_q  <= RST_WORD;
			acc_q <= RST_WORD;
			tmp_q <= RST_WORD;
		end else begin
			pc_q  <= pc_d;
			acc_q <= acc_d;
			tmp_q <= (wr & sel_tmp) ? pwdata_i[15:0] : tmp_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			idx_q <= RST_WORD;
			ext_q <= RST_WORD;
			stk_q <= RST_WORD;
		end else begin
			idx_q <= (wr & sel_idx) ? pwdata_i[15:0] : idx_q;
			ext_q <= (wr & sel_ext) ? pwdata_i[15:0] : ext_q;
			stk_q <= (wr & sel_stk) ? pwdata_i[15:0] : stk_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			bank_q   <= RST_BANK;
			ccr_q    <= RST_CCR;
			lastop_q <= 4'h0;
		end else begin
			bank_q   <= bank_d;
			ccr_q    <= ccr_d;
			lastop_q <= op_go ? pwdata_i[3:0] : lastop_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			gpr_num_q  <= 3'h0;
			probe_q    <= 16'h0000;
			irq_take_q <= 1'b0;
			gpr_addr_q <= GPR_BASE;
		end else begin
			gpr_num_q  <= (wr & sel_gpr) ? pwdata_i[2:0] : gpr_num_q;
			probe_q    <= (wr & sel_probe) ? pwdata_i[15:0] : probe_q;
			irq_take_q <= take_d;
			gpr_addr_q <= gpr_addr;
		end
	end

	// ========================================
	// outputs
	assign prdata_o          = prdata_q;
	assign pready_o          = pready_q;
	assign pslverr_o         = pslverr_q;
	assign irq_take_o        = irq_take_q;
	assign program_counter_o = pc_q;
	assign program_status_o  = {bank_q, ccr_q};
	assign gpr_addr_o        = gpr_addr_q;

	// ========================================
	// checks
	a_carry_byte_add: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_ADD && !op_wide) |=> ccr_q[CC_C] ==
		(({1'b0, $past(acc_q[7:0])} + {1'b0, $past(tmp_q[7:0])}) > 9'h0ff))
		else $error("carry wrong after byte add");

	a_half_carry_add: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_ADD && !op_wide) |=> ccr_q[CC_H] ==
		(({1'b0, $past(acc_q[3:0])} + {1'b0, $past(tmp_q[3:0])}) > 5'h0f))
		else $error("half carry wrong after add");

	a_shift_out_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_SHR) |=> ccr_q[CC_C] == $past(acc_q[0]))
		else $error("shift-out bit not in carry");

	a_zero_flag_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && !op_wide) |=> ccr_q[CC_Z] == (acc_q[7:0] == 8'h00))
		else $error("zero flag disagrees with result");

	a_neg_flag_word: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_wide) |=> ccr_q[CC_N] == acc_q[15])
		else $error("negative flag disagrees with msb");

	a_high_byte_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && !op_wide) |=> acc_q[15:8] == $past(acc_q[15:8]))
		else $error("byte op disturbed high byte");

	a_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ccr_q[CC_I] |=> !irq_take_o)
		else $error("interrupt taken while disabled");

	a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
		(irq_req_i && ccr_q[CC_I]) |=>
		irq_take_o == ((($past(irq_level_i) == 2'h0) ? 2'h1 : $past(irq_level_i)) <
		(($past(ccr_q[CC_IL_H:CC_IL_L]) == 2'h0) ? 2'h1 : $past(ccr_q[CC_IL_H:CC_IL_L]))))
		else $error("interrupt level compare wrong");

	a_reset_ie_clear: assert property (@(posedge mclk_i)
		rst_i |=> !ccr_q[CC_I])
		else $error("interrupt enable not cleared by reset");

	a_step_counter: assert property (@(posedge mclk_i) disable iff (rst_i)
		do_step |=> pc_q == $past(pc_q) + 16'h0001)
		else $error("program counter did not advance");

	a_ready_spacing: assert property (@(posedge mclk_i) disable iff (rst_i)
		(in_access && !pready_q) |=> pready_q ##1 !pready_q)
		else $error("ready not a single cycle");

	a_borrow_byte_sub: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_SUB && !op_wide) |=> ccr_q[CC_C] ==
		($past(acc_q[7:0]) < $past(tmp_q[7:0])))
		else $error("borrow wrong after byte subtract");

	a_carry_word_add: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_ADD && op_wide) |=> ccr_q[CC_C] ==
		(({1'b0, $past(acc_q)} + {1'b0, $past(tmp_q)}) > 17'h0ffff))
		else $error("carry wrong after word add");

	a_overflow_byte_add: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_ADD && !op_wide) |=> ccr_q[CC_V] ==
		(($past(acc_q[7]) == $past(tmp_q[7])) && (acc_q[7] != $past(acc_q[7]))))
		else $error("overflow wrong after byte add");

	a_shift_left_out: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_code == OP_SHL && !op_wide) |=> ccr_q[CC_C] == $past(acc_q[7]))
		else $error("left shift-out bit not in carry");

	a_shift_keeps_hv: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && is_shift) |=>
		(ccr_q[CC_H] == $past(ccr_q[CC_H])) && (ccr_q[CC_V] == $past(ccr_q[CC_V])))
		else $error("shift disturbed half carry or overflow");

	a_neg_flag_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && !op_wide) |=> ccr_q[CC_N] == acc_q[7])
		else $error("negative flag disagrees with byte msb");

	a_zero_flag_word: assert property (@(posedge mclk_i) disable iff (rst_i)
		(do_alu && op_wide) |=> ccr_q[CC_Z] == (acc_q == 16'h0000))
		else $error("zero flag disagrees with word result");

	a_tmp_written: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr && sel_tmp) |=> tmp_q == $past(pwdata_i[15:0]))
		else $error("temporary accumulator write lost");

	a_stack_written: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr && sel_stk) |=> stk_q == $past(pwdata_i[15:0]))
		else $error("stack pointer write lost");

	a_status_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr && sel_ps) |=> program_status_o == $past(pwdata_i[15:0]))
		else $error("status word halves misplaced");

	a_gpr_in_data: assert property (@(posedge mclk_i) disable iff (rst_i)
		(gpr_addr_o >= IO_END) && (gpr_addr_o < PROG_BASE))
		else $error("register address outside data area");

	a_reg_number_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> gpr_addr_o[2:0] == $past(gpr_num_q))
		else $error("register number not in low address bits");

	a_vector_top: assert property (@(posedge mclk_i) disable iff (rst_i)
		(probe_q >= VECTOR_BASE) |-> region == RGN_VECTOR)
		else $error("top addresses not in vector region");

endmodule // cpu_register_set_and_flags

// ===== testbench/cpu_register_set_and_flags_tb.sv
// self-checking bench for the core register set and condition flags
`timescale 1ns/1ps
module cpu_register_set_and_flags_tb
	import core_regs_pkg::*;
;
	typedef struct {
		logic [15:0] a;
		logic [15:0] t;
		logic [3:0]  op;
		logic [15:0] res;
		logic [7:0]  fl;
		logic [7:0]  mk;
	} alu_row_s;

	logic        mclk_i;
	logic        rst_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        irq_req_i;
	logic [1:0]  irq_level_i;
	logic        irq_take_o;
	logic [15:0] program_counter_o;
	logic [15:0] program_status_o;
	logic [15:0] gpr_addr_o;
	logic [31:0] rd_v;
	logic        er_v;
	int          n_fail;
	int          checks_done;

	// carry masked only in the last row, a word add whose byte and word carry readings would differ
	alu_row_s rows [10] = '{
		'{16'h120f, 16'h0001, 4'h1, 16'h1210, 8'h80, 8'h8f},
		'{16'h007f, 16'h0001, 4'h1, 16'h0080, 8'h8a, 8'h8f},
		'{16'h00ff, 16'h0001, 4'h1, 16'h0000, 8'h85, 8'h8f},
		'{16'h0010, 16'h0001, 4'h2, 16'h000f, 8'h80, 8'h8f},
		'{16'h0000, 16'h0001, 4'h2, 16'h00ff, 8'h89, 8'h8f},
		'{16'h0080, 16'h0001, 4'h2, 16'h007f, 8'h82, 8'h8f},
		'{16'h0081, 16'h0000, 4'h3, 16'h0002, 8'h01, 8'h8f},
		'{16'h0001, 16'h0000, 4'h4, 16'h0000, 8'h05, 8'h8f},
		'{16'h7f00, 16'h0100, 4'h9, 16'h8000, 8'h0a, 8'h8f},
		'{16'h0180, 16'h0080, 4'h9, 16'h0200, 8'h00, 8'h8e}
	};
	logic [15:0] probes [6] = '{16'h007f, 16'h0080, 16'h7fff, 16'h8000, 16'hffbf, 16'hffc0};
	logic [1:0]  regions [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	logic [11:0] word_ofs [6] = '{OFS_PC, OFS_ACC, OFS_TMP, OFS_IDX, OFS_EXT, OFS_STK};

	cpu_register_set_and_flags #(.NUM_BANKS(32), .ADDR_W(12)) uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.irq_req_i(irq_req_i), .irq_level_i(irq_level_i), .irq_take_o(irq_take_o),
		.program_counter_o(program_counter_o), .program_status_o(program_status_o),
		.gpr_addr_o(gpr_addr_o)
	);

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// ========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ready is sampled at the edge itself, before that edge's updates land
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic irq_try(input logic [1:0] lvl, input logic exp);
		@(posedge mclk_i);
		irq_req_i <= 1'b1;
		irq_level_i <= lvl;
		@(posedge mclk_i);
		irq_req_i <= 1'b0;
		@(negedge mclk_i);
		chk({31'h0, irq_take_o}, {31'h0, exp});
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ========================================
	// watchdog: whole run is a few hundred cycles
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end

	// ========================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		irq_req_i = 1'b0;
		irq_level_i = 2'h3;
		n_fail = 0;
		checks_done = 0;
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		chk({16'h0, program_status_o}, 32'h0000_0030);
		chk({16'h0, gpr_addr_o}, 32'h0000_0100);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, word_ofs[i], 32'h0, rd_v, er_v);
			chk(rd_v, 32'h0);
			wr(word_ofs[i], {16'hffff, 16'h1111 * 16'(i + 1)});
			apb(1'b0, word_ofs[i], 32'h0, rd_v, er_v);
			chk(rd_v, {16'h0, 16'h1111 * 16'(i + 1)});
		end
		chk({16'h0, program_counter_o}, 32'h0000_1111);
		$display("test word registers done");

		foreach (rows[i]) begin
			wr(OFS_PS, 32'h0000_0030);
			wr(OFS_ACC, {16'h0, rows[i].a});
			wr(OFS_TMP, {16'h0, rows[i].t});
			wr(OFS_OP, {28'h0, rows[i].op});
			apb(1'b0, OFS_ACC, 32'h0, rd_v, er_v);
			chk(rd_v, {16'h0, rows[i].res});
			chk({24'h0, program_status_o[7:0] & rows[i].mk}, {24'h0, rows[i].fl & rows[i].mk});
		end
		$display("test flag table done");

		wr(OFS_PC, 32'h0000_fffe);
		wr(OFS_OP, 32'h0000_0005);
		@(negedge mclk_i);
		chk({16'h0, program_counter_o}, 32'h0000_ffff);
		wr(OFS_OP, 32'h0000_0005);
		@(negedge mclk_i);
		chk({16'h0, program_counter_o}, 32'h0000_0000);
		$display("test program counter step done");

		apb(1'b1, 12'h028, 32'hffff_ffff, rd_v, er_v);
		chk({31'h0, er_v}, 32'h1);
		apb(1'b0, 12'h028, 32'h0, rd_v, er_v);
		chk({31'h0, er_v}, 32'h1);
		chk(rd_v, 32'h0);
		$display("test unmapped address done");

		wr(OFS_PS, 32'h0000_1f30);
		wr(OFS_GPR, 32'h0000_0007);
		repeat (2) @(posedge mclk_i);
		chk({16'h0, program_status_o}, 32'h0000_1f30);
		chk({16'h0, gpr_addr_o}, 32'h0000_01ff);
		wr(OFS_PS, 32'h0000_0330);
		wr(OFS_GPR, 32'h0000_0005);
		apb(1'b0, OFS_GPR, 32'h0, rd_v, er_v);
		chk(rd_v, 32'h011d_0005);
		foreach (probes[i]) begin
			wr(OFS_PROBE, {16'h0, probes[i]});
			apb(1'b0, OFS_PROBE, 32'h0, rd_v, er_v);
			chk(rd_v, {14'h0, regions[i], probes[i]});
		end
		$display("test banks and map done");

		wr(OFS_PS, 32'h0000_0060);
		irq_try(2'h1, 1'b1);
		irq_try(2'h0, 1'b1);
		irq_try(2'h2, 1'b0);
		irq_try(2'h3, 1'b0);
		wr(OFS_PS, 32'h0000_0030);
		irq_try(2'h0, 1'b0);
		// codes 00 and 01 are one level: neither outranks the other
		wr(OFS_PS, 32'h0000_0050);
		irq_try(2'h0, 1'b0);
		wr(OFS_PS, 32'h0000_0070);
		wr(OFS_PC, 32'h0000_1234);
		$display("test interrupt gate done");

		// second reset mid-run must clear the enable flag again
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		chk({16'h0, program_status_o}, 32'h0000_0030);
		chk({16'h0, program_counter_o}, 32'h0);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule // cpu_register_set_and_flags_tb
